// >>> shared/wdtrn_pkg.sv
// Operation
// RULE_01: watchdog starts disabled after every system reset
// RULE_02: enable bit sets by writing one, sticky
// RULE_03: period field picks 2^27, 2^25, 2^22, 2^18
// RULE_04: clock field picks system or rtc source
// RULE_05: every time-out sets the cause flag
// RULE_06: response bit picks reset or nmi
// RULE_07: reset and nmi outputs change on clock edges
// RULE_08: cause flag read-only, cleared by full reset only
// RULE_09: a5 then 5a reloads counter, counting resumes
// RULE_10: software finishes service before the period expires
// RULE_11: eight-bit control, bit 2 reads zero
// RULE_12: service location is write-only, reads zero
// RULE_13: wrong second byte abandons the service sequence
package wdtrn_pkg;

   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_CTL = 10'h093;   // watchdog_control
   localparam logic [9:0] IDX_SVC = 10'h094;   // watchdog_service
   localparam logic [9:0] IDX_STS = 10'h095;   // event status, write one clears
   localparam logic [9:0] IDX_MSK = 10'h096;   // event mask

   // control field positions
   localparam int EN_BIT   = 7;   // watchdog_enable_bit
   localparam int NMI_BIT  = 6;   // response select
   localparam int FLAG_BIT = 5;   // time-out cause flag
   localparam int CLK_HI   = 4;   // count_clock_select msb
   localparam int CLK_LO   = 3;   // count_clock_select lsb
   localparam int PER_HI   = 1;   // timeout_period_select msb
   localparam int PER_LO   = 0;   // timeout_period_select lsb

   // count clock selections; the other two codes count nothing
   localparam logic [1:0] CLKSEL_SYS = 2'h0;
   localparam logic [1:0] CLKSEL_RTC = 2'h1;

   // period exponents per selection code 00..11
   localparam int PER_EXP_0 = 27;
   localparam int PER_EXP_1 = 25;
   localparam int PER_EXP_2 = 22;
   localparam int PER_EXP_3 = 18;
   localparam int CNT_W     = 27;   // wide enough for the longest period

   // service sequence bytes
   localparam logic [7:0] SVC_FIRST  = 8'hA5;
   localparam logic [7:0] SVC_SECOND = 8'h5A;

   // event status bits
   localparam int EV_W       = 3;
   localparam int EV_TIMEOUT = 0;
   localparam int EV_SERVICE = 1;
   localparam int EV_ABORT   = 2;

   // service sequence states, one-hot
   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b01,   // waiting for the first byte
      SEQ_ARMED = 2'b10    // first byte seen, waiting for the second
   } wdtrn_seq_type;

   // wishbone request from the master
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [11:0] adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wdtrn_wb_req_type;

   // wishbone answer to the master
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wdtrn_wb_rsp_type;

   // whole state of the top module
   typedef struct packed {
      logic            ack;       // bus acknowledge
      logic [31:0]     rdat;      // bus read data
      logic            en;        // watchdog running
      logic            nmi_sel;   // time-out raises nmi instead of reset
      logic            flag;      // time-out cause flag
      logic [1:0]      clk_sel;   // counting clock
      logic [1:0]      per_sel;   // period selection
      wdtrn_seq_type   seq;       // service sequence state
      logic            reload;    // counter reload pulse
      logic [EV_W-1:0] status;    // sticky events
      logic [EV_W-1:0] mask;      // event enables
      logic            rst_req;   // chip reset request
      logic            nmi;       // nmi pulse
      logic            irq;       // interrupt level
   } wdtrn_top_state_type;

   // whole state of the counter
   typedef struct packed {
      logic             rtc_prev;   // last rtc level, for edge detect
      logic [CNT_W-1:0] cnt;        // elapsed ticks
      logic             tmo;        // time-out pulse
   } wdtrn_cnt_state_type;

endpackage

// >>> rtl/wdtrn_counter.sv
`timescale 1ns/100ps
// tick counter: counts the selected clock and pulses on expiry
module wdtrn_counter #(
   parameter int EXP_0 = wdtrn_pkg::PER_EXP_0,
   parameter int EXP_1 = wdtrn_pkg::PER_EXP_1,
   parameter int EXP_2 = wdtrn_pkg::PER_EXP_2,
   parameter int EXP_3 = wdtrn_pkg::PER_EXP_3
) (
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       enable,
   input  wire logic [1:0] per_sel,
   input  wire logic [1:0] clk_sel,
   input  wire logic       rtc_src,
   input  wire logic       reload,
   output logic            timeout
);

   wdtrn_pkg::wdtrn_cnt_state_type st_r;     // registered state
   wdtrn_pkg::wdtrn_cnt_state_type st_nxt;   // next state
   logic                           tick;     // one counting event
   logic [wdtrn_pkg::CNT_W-1:0]    lim;      // last count before expiry

   // last count of a period: two to the exponent, less one
   function automatic logic [wdtrn_pkg::CNT_W-1:0] limit(
      input logic [1:0] sel);
      int e;
      begin
         case (sel)
            2'h0:    e = EXP_0;
            2'h1:    e = EXP_1;
            2'h2:    e = EXP_2;
            default: e = EXP_3;
         endcase
         limit = wdtrn_pkg::CNT_W'((64'h1 << e) - 64'h1);
      end
   endfunction

   // tick select, count, expiry
   always_comb begin
      st_nxt = st_r;
      lim = limit(per_sel);   // see RULE_03
      case (clk_sel)   // see RULE_04
         wdtrn_pkg::CLKSEL_SYS: tick = 1'b1;
         wdtrn_pkg::CLKSEL_RTC: tick = rtc_src & ~st_r.rtc_prev;
         default:               tick = 1'b0;   // reserved codes halt
      endcase
      st_nxt.rtc_prev = rtc_src;
      st_nxt.tmo = 1'b0;
      if (!resetn) begin
         st_nxt = '0;   // see RULE_01
         // track the pin through reset so release gives no false tick
         st_nxt.rtc_prev = rtc_src;
      end else if (enable) begin
         // >= so that shortening the period mid-count still expires
         if (tick && st_r.cnt >= lim) begin
            st_nxt.tmo = 1'b1;   // expiry beats a late reload
            st_nxt.cnt = '0;
         end else if (reload) begin
            st_nxt.cnt = '0;     // see RULE_09
         end else if (tick) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
         end
      end else begin
         st_nxt.cnt = '0;
      end
   end

   // single state register
   always_ff @(posedge sys_clk) begin
      st_r <= st_nxt;
   end

   assign timeout = st_r.tmo;

   // expiry only at or past the selected limit
   AST_EXPIRE_AT_LIMIT: assert property (@(posedge sys_clk)  // see RULE_03
      disable iff (!resetn)
      st_r.tmo |-> $past(st_r.cnt) >= $past(lim))
      else $error("time-out before the period limit");

   // reserved clock codes never advance the count
   AST_RESERVED_CLOCK: assert property (@(posedge sys_clk)  // see RULE_04
      disable iff (!resetn)
      (clk_sel[1] && !reload && enable) |=> !st_r.tmo && $stable(st_r.cnt))
      else $error("count moved on a reserved clock selection");

endmodule // wdtrn_counter

// >>> rtl/wdtrn_top.sv
`timescale 1ns/100ps
// watchdog_unit: wishbone registers, service sequence, time-out response
module wdtrn_top #(
   parameter int EXP_0 = wdtrn_pkg::PER_EXP_0,   // 2^27 ticks
   parameter int EXP_1 = wdtrn_pkg::PER_EXP_1,   // 2^25 ticks
   parameter int EXP_2 = wdtrn_pkg::PER_EXP_2,   // 2^22 ticks
   parameter int EXP_3 = wdtrn_pkg::PER_EXP_3    // 2^18 ticks
) (
   input  wire logic                         sys_clk,
   input  wire logic                         resetn,
   input  wire logic                         full_resetn,
   input  wire logic                         rtc_src,
   input  wire wdtrn_pkg::wdtrn_wb_req_type  wb_req,
   output wdtrn_pkg::wdtrn_wb_rsp_type       wb_rsp,
   output logic                              wdt_reset_req,
   output logic                              wdt_nmi,
   output logic                              irq
);

   wdtrn_pkg::wdtrn_top_state_type st_r;      // registered state
   wdtrn_pkg::wdtrn_top_state_type st_nxt;    // next state
   logic                           tmo;       // counter expiry pulse
   logic                           wr;        // write accepted now
   logic                           rd;        // read accepted now
   logic [7:0]                     wbyte;     // low write byte
   logic [wdtrn_pkg::EV_W-1:0]     ev;        // events this cycle
   logic [wdtrn_pkg::EV_W-1:0]     clr;       // status bits cleared

   // address match against a register index
   function automatic logic hit(input logic [11:0] adr,
                                input logic [9:0]  idx);
      hit = (adr[11:2] == idx);
   endfunction

   // control register image as software reads it
   function automatic logic [7:0] ctl_image(
      input wdtrn_pkg::wdtrn_top_state_type s);
      logic [7:0] v;
      begin
         v = 8'h00;   // bit 2 stays zero
         v[wdtrn_pkg::EN_BIT] = s.en;
         v[wdtrn_pkg::NMI_BIT] = s.nmi_sel;
         v[wdtrn_pkg::FLAG_BIT] = s.flag;
         v[wdtrn_pkg::CLK_HI:wdtrn_pkg::CLK_LO] = s.clk_sel;
         v[wdtrn_pkg::PER_HI:wdtrn_pkg::PER_LO] = s.per_sel;
         ctl_image = v;
      end
   endfunction

   // counting datapath
   wdtrn_counter #(
      .EXP_0 (EXP_0),
      .EXP_1 (EXP_1),
      .EXP_2 (EXP_2),
      .EXP_3 (EXP_3)
   ) u_counter (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .enable  (st_r.en),
      .per_sel (st_r.per_sel),
      .clk_sel (st_r.clk_sel),
      .rtc_src (rtc_src),
      .reload  (st_r.reload),
      .timeout (tmo)
   );

   // bus decode, register writes, sequence, events and responses
   always_comb begin
      st_nxt = st_r;
      // one request per ack; the cycle with ack high blocks a repeat
      wr = wb_req.cyc & wb_req.stb & wb_req.we & ~st_r.ack;
      rd = wb_req.cyc & wb_req.stb & ~wb_req.we & ~st_r.ack;
      wbyte = wb_req.dat[7:0];
      ev = '0;
      clr = '0;
      st_nxt.ack = wr | rd;
      st_nxt.reload = 1'b0;
      st_nxt.nmi = 1'b0;

      // control writes, only through byte lane 0
      if (wr && wb_req.sel[0] && hit(wb_req.adr, wdtrn_pkg::IDX_CTL)) begin
         // zero is ignored once running
         st_nxt.en = st_r.en | wbyte[wdtrn_pkg::EN_BIT];   // see RULE_02
         st_nxt.nmi_sel = wbyte[wdtrn_pkg::NMI_BIT];      // see RULE_06
         st_nxt.clk_sel =
            wbyte[wdtrn_pkg::CLK_HI:wdtrn_pkg::CLK_LO];   // see RULE_04
         st_nxt.per_sel =
            wbyte[wdtrn_pkg::PER_HI:wdtrn_pkg::PER_LO];   // see RULE_03
      end

      // service sequence; the byte itself is never stored
      if (wr && wb_req.sel[0] && hit(wb_req.adr, wdtrn_pkg::IDX_SVC)) begin
         case (st_r.seq)
            wdtrn_pkg::SEQ_IDLE: begin
               if (wbyte == wdtrn_pkg::SVC_FIRST) begin
                  st_nxt.seq = wdtrn_pkg::SEQ_ARMED;
               end
            end
            wdtrn_pkg::SEQ_ARMED: begin
               st_nxt.seq = wdtrn_pkg::SEQ_IDLE;
               if (wbyte == wdtrn_pkg::SVC_SECOND) begin
                  st_nxt.reload = 1'b1;   // see RULE_09
                  ev[wdtrn_pkg::EV_SERVICE] = 1'b1;
               end else begin
                  ev[wdtrn_pkg::EV_ABORT] = 1'b1;   // see RULE_13
               end
            end
            default: st_nxt.seq = wdtrn_pkg::SEQ_IDLE;
         endcase
      end

      // status write-one-to-clear and mask
      if (wr && wb_req.sel[0] && hit(wb_req.adr, wdtrn_pkg::IDX_STS)) begin
         clr = wbyte[wdtrn_pkg::EV_W-1:0];
      end
      if (wr && wb_req.sel[0] && hit(wb_req.adr, wdtrn_pkg::IDX_MSK)) begin
         st_nxt.mask = wbyte[wdtrn_pkg::EV_W-1:0];
      end

      // read data; service and unmapped words read zero
      if (rd) begin
         st_nxt.rdat = '0;
         if (hit(wb_req.adr, wdtrn_pkg::IDX_CTL)) begin
            st_nxt.rdat[7:0] = ctl_image(st_r);   // see RULE_11
         end else if (hit(wb_req.adr, wdtrn_pkg::IDX_STS)) begin
            st_nxt.rdat[wdtrn_pkg::EV_W-1:0] = st_r.status;
         end else if (hit(wb_req.adr, wdtrn_pkg::IDX_MSK)) begin
            st_nxt.rdat[wdtrn_pkg::EV_W-1:0] = st_r.mask;
         end else begin
            st_nxt.rdat = '0;   // see RULE_12
         end
      end else begin
         st_nxt.rdat = '0;
      end

      // time-out response, launched from registered state only
      if (tmo) begin
         ev[wdtrn_pkg::EV_TIMEOUT] = 1'b1;
         st_nxt.flag = 1'b1;   // see RULE_05
         if (st_r.nmi_sel) begin
            st_nxt.nmi = 1'b1;   // see RULE_06
         end else begin
            st_nxt.rst_req = 1'b1;   // see RULE_07
         end
      end

      // an event in the clearing cycle survives: set beats clear
      st_nxt.status = (st_r.status & ~clr) | ev;

      // system reset: everything but the cause flag
      if (!resetn) begin
         st_nxt.ack = 1'b0;   // see RULE_01
         st_nxt.rdat = '0;
         st_nxt.en = 1'b0;
         st_nxt.nmi_sel = 1'b0;
         st_nxt.clk_sel = wdtrn_pkg::CLKSEL_SYS;
         st_nxt.per_sel = 2'h0;
         st_nxt.seq = wdtrn_pkg::SEQ_IDLE;
         st_nxt.reload = 1'b0;
         st_nxt.status = '0;
         st_nxt.mask = '0;
         st_nxt.rst_req = 1'b0;   // the reset it asked for ends it
         st_nxt.nmi = 1'b0;
      end
      // the flag outlives a watchdog reset so software can see the cause
      if (!full_resetn) begin
         st_nxt.flag = 1'b0;   // see RULE_08
      end

      // level irq, same cycle as the status it reflects
      st_nxt.irq = |(st_nxt.status & st_nxt.mask);
   end

   // single state register, synchronous reset handled above
   always_ff @(posedge sys_clk) begin
      st_r <= st_nxt;
   end

   // outputs straight from state
   assign wb_rsp.ack    = st_r.ack;
   assign wb_rsp.dat    = st_r.rdat;
   assign wdt_reset_req = st_r.rst_req;
   assign wdt_nmi       = st_r.nmi;
   assign irq           = st_r.irq;

   default clocking cb @(posedge sys_clk);
   endclocking

   default disable iff (!resetn);

   // a write to control with the enable bit
   sequence ctl_enable_write;
      wb_req.cyc && wb_req.stb && wb_req.we && !st_r.ack
         && wb_req.sel[0] && hit(wb_req.adr, wdtrn_pkg::IDX_CTL)
         && wb_req.dat[wdtrn_pkg::EN_BIT];
   endsequence

   // a write of a given byte to the service location
   sequence svc_write(logic [7:0] b);
      wb_req.cyc && wb_req.stb && wb_req.we && !st_r.ack
         && wb_req.sel[0] && hit(wb_req.adr, wdtrn_pkg::IDX_SVC)
         && wb_req.dat[7:0] == b;
   endsequence

   AST_OFF_AFTER_RESET: assert property (  // see RULE_01
      $rose(resetn) |-> !st_r.en && !st_r.rst_req && !st_r.nmi)
      else $error("watchdog not idle after reset");

   AST_ENABLE_STICKS: assert property (  // see RULE_02
      st_r.en |=> st_r.en [*8])
      else $error("enable bit cleared without reset");

   AST_ENABLE_SETS: assert property (  // see RULE_02
      ctl_enable_write |=> st_r.en && st_r.ack)
      else $error("enable write did not start the watchdog");

   AST_FLAG_ON_TIMEOUT: assert property (  // see RULE_05
      tmo && full_resetn |=> st_r.flag && st_r.status[wdtrn_pkg::EV_TIMEOUT])
      else $error("time-out did not set the cause flag");

   AST_RESPONSE_SELECT: assert property (  // see RULE_06
      tmo |=> (st_r.nmi == $past(st_r.nmi_sel))
         && (st_r.rst_req == !$past(st_r.nmi_sel) || $past(st_r.rst_req)))
      else $error("wrong time-out response");

   AST_RESET_EDGE: assert property (  // see RULE_07
      $rose(st_r.rst_req) |-> $past(tmo) && !$past(st_r.nmi_sel))
      else $error("reset request rose without a time-out");

   AST_FLAG_KEPT: assert property (  // see RULE_08
      @(posedge sys_clk) disable iff (!full_resetn)
      st_r.flag |=> st_r.flag)
      else $error("cause flag lost without a full reset");

   // upper byte lanes are always zero; bit 2 is reserved only in control,
   // status and mask legitimately carry their bit 2
   AST_RESERVED_READ: assert property (  // see RULE_11
      st_r.ack |-> st_r.rdat[31:8] == 24'h000000
         && (st_r.rdat[2] == 1'b0 || $past(wb_req.we)
             || $past(wb_req.adr[11:2]) != wdtrn_pkg::IDX_CTL))
      else $error("reserved read bits not zero");

   AST_SERVICE_RELOAD: assert property (  // see RULE_09
      st_r.seq == wdtrn_pkg::SEQ_ARMED ##0 svc_write(wdtrn_pkg::SVC_SECOND)
      |=> st_r.reload ##1 !st_r.reload)
      else $error("service sequence did not reload the counter");

   AST_SERVICE_ABORT: assert property (  // see RULE_13
      st_r.seq == wdtrn_pkg::SEQ_ARMED ##0 wb_req.cyc && wb_req.stb
      && wb_req.we && !st_r.ack && wb_req.sel[0]
      && hit(wb_req.adr, wdtrn_pkg::IDX_SVC)
      && wb_req.dat[7:0] != wdtrn_pkg::SVC_SECOND
      |=> !st_r.reload && st_r.seq == wdtrn_pkg::SEQ_IDLE)
      else $error("bad second byte did not abandon the sequence");

   AST_SERVICE_READS_ZERO: assert property (  // see RULE_12
      wb_req.cyc && wb_req.stb && !wb_req.we && !st_r.ack
      && hit(wb_req.adr, wdtrn_pkg::IDX_SVC)
      |=> st_r.ack && st_r.rdat == 32'h00000000)
      else $error("service location read back data");

   COV_RESET_TIMEOUT: cover property (tmo && !st_r.nmi_sel ##1 st_r.rst_req);
   COV_NMI_TIMEOUT: cover property (tmo && st_r.nmi_sel ##1 st_r.nmi);
   COV_SERVICE: cover property (svc_write(wdtrn_pkg::SVC_FIRST)
      ##[1:20] svc_write(wdtrn_pkg::SVC_SECOND));
   COV_IRQ: cover property ($rose(st_r.irq));

endmodule // wdtrn_top

// >>> verif/wdtrn_chip_model.sv
`timescale 1ns/100ps
// chip side of the watchdog_unit: reset logic and a free-running rtc source
module wdtrn_chip_model (
   input  wire logic sys_clk,         // 50 MHz system clock
   input  wire logic por_n,           // power-on / debug reset request
   input  wire logic warm_n,          // plain system reset request
   input  wire logic wdt_reset_req,   // time-out reset request
   output logic      resetn,          // system reset to the block
   output logic      full_resetn,     // full-chip reset to the block
   output logic      rtc_src          // real-time clock source level
);
   logic       resetn_r   = 1'b0;     // starts in reset until por_n rises
   logic [2:0] rtc_div_r  = 3'h0;     // rtc divider, one tick per 8 cycles

   // reset is registered so it changes on clock edges like the real chip;
   // a time-out request yields exactly two reset cycles, as the block drops
   // it at the first edge that sees reset, so a stuck request would show as a stuck reset
   always @(posedge sys_clk) begin
      resetn_r  <= por_n & warm_n & ~wdt_reset_req;
      rtc_div_r <= rtc_div_r + 3'h1;
   end

   assign resetn      = resetn_r;
   // only the full-chip path reaches the cause flag
   assign full_resetn = por_n;
   // the rtc oscillator runs free, it never stops between time-outs
   assign rtc_src     = rtc_div_r[2];
endmodule // wdtrn_chip_model

// >>> verif/wdtrn_top_test.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("unexpected at %0t got %0h expected %0h", $time, (a), (b)); \
   end end
// self-checking bench for the watchdog_unit over wishbone
module wdtrn_top_test;
   logic                        sys_clk;         // bench clock
   logic                        por_n;           // full reset request
   logic                        warm_n;          // system reset request
   logic                        resetn;          // from chip model
   logic                        full_resetn;     // from chip model
   logic                        rtc_src;         // from chip model
   wdtrn_pkg::wdtrn_wb_req_type wb_req;          // bus master request
   wdtrn_pkg::wdtrn_wb_rsp_type wb_rsp;          // slave answer
   logic                        wdt_reset_req;   // time-out reset
   logic                        wdt_nmi;         // time-out nmi pulse
   logic                        irq;             // event interrupt
   int                          n_mismatch = 0;  // mismatches seen
   int                          checks     = 0;  // comparisons made
   int                          n_nmi      = 0;  // nmi pulses seen
   int                          per_exp[4] = '{6, 5, 4, 3}; // shortened
   int                          c;               // measured cycles
   int                          n0;              // nmi count snapshot
   logic [31:0]                 x;               // read data

   // short periods keep the run small; expectations use per_exp
   wdtrn_top #(.EXP_0(6), .EXP_1(5), .EXP_2(4), .EXP_3(3)) DUT (
      .sys_clk       (sys_clk),
      .resetn        (resetn),
      .full_resetn   (full_resetn),
      .rtc_src       (rtc_src),
      .wb_req        (wb_req),
      .wb_rsp        (wb_rsp),
      .wdt_reset_req (wdt_reset_req),
      .wdt_nmi       (wdt_nmi),
      .irq           (irq)
   );

   wdtrn_chip_model chip (
      .sys_clk       (sys_clk),
      .por_n         (por_n),
      .warm_n        (warm_n),
      .wdt_reset_req (wdt_reset_req),
      .resetn        (resetn),
      .full_resetn   (full_resetn),
      .rtc_src       (rtc_src)
   );

   // 20 ns clock, rising edges at 10, 30, 50 ns
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // nmi pulses are counted with nba so waiters see a stable value
   always @(posedge sys_clk) begin
      if (wdt_nmi === 1'b1) begin
         n_nmi <= n_nmi + 1;
      end
   end

   // time-out outputs may only move at a rising clock edge
   always @(wdt_reset_req, wdt_nmi) begin
      if ($time > 0) begin
         `CHK($time % 20, 64'd10)
      end
   end

   // one classic cycle; ack is sampled at the edge before its update lands
   task automatic wb_xfer(input logic we, input logic [9:0] idx,
                          input logic [7:0] wd, output logic [31:0] rd);
      int t;
      t = 0;
      @(posedge sys_clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'h0},
                  sel: 4'hF, dat: {24'h000000, wd}};
      do begin
         @(posedge sys_clk);
         t++;
      end while (wb_rsp.ack !== 1'b1 && t < 50);
      rd = wb_rsp.dat;
      wb_req <= '0;
      if (t >= 50) begin
         n_mismatch++;   // slave never answered
      end
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic [31:0] y;
      wb_xfer(1'b1, idx, d, y);
   endtask

   task automatic chk_rd(input logic [9:0] idx, input logic [31:0] e);
      logic [31:0] y;
      wb_xfer(1'b0, idx, 8'h00, y);
      `CHK(y, e)
   endtask

   // waits for the next nmi pulse, returns the cycles spent waiting
   task automatic wait_nmi(input int lim, output int cyc);
      int k;
      k = n_nmi;
      cyc = 0;
      while (n_nmi == k && cyc < lim) begin
         @(posedge sys_clk);
         cyc++;
      end
   endtask

   // waits for a reset request, bounded
   task automatic wait_req(input int lim, output int cyc);
      cyc = 0;
      while (wdt_reset_req !== 1'b1 && cyc < lim) begin
         @(posedge sys_clk);
         cyc++;
      end
   endtask

   task automatic give_verdict;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // the whole run is near 1050 cycles; 5000 means a hang
   initial begin
      #100000;
      n_mismatch++;
      give_verdict;
   end

   initial begin
      wb_req = '0;
      por_n  = 1'b0;
      warm_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      por_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      // reset values, write-only and unmapped places
      chk_rd(wdtrn_pkg::IDX_CTL, 32'h00000000);
      chk_rd(wdtrn_pkg::IDX_SVC, 32'h00000000);
      chk_rd(10'h0A0, 32'h00000000);
      // flag and bit 2 ignore writes
      wr(wdtrn_pkg::IDX_CTL, 8'h3F);
      chk_rd(wdtrn_pkg::IDX_CTL, 32'h0000001B);
      // reserved clock code: enabled but nothing counts
      wr(wdtrn_pkg::IDX_CTL, 8'h9B);
      wait_req(100, c);
      `CHK({wdt_reset_req, n_nmi == 0}, 2'h1)
      warm_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      warm_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk_rd(wdtrn_pkg::IDX_CTL, 32'h00000000);
      // reset response, system clock, shortest period
      wr(wdtrn_pkg::IDX_CTL, 8'h83);
      wait_req(40, c);
      `CHK(c >= 8 && c <= 11, 1'b1)
      `CHK(wdt_reset_req, 1'b1)
      repeat (4) @(posedge sys_clk);
      // flag survives the watchdog reset, enable does not
      chk_rd(wdtrn_pkg::IDX_CTL, 32'h00000020);
      `CHK(n_nmi, 0)
      // nmi response counting rtc ticks, 32 ticks of 8 cycles
      wr(wdtrn_pkg::IDX_CTL, 8'hC9);
      wait_nmi(400, c);
      `CHK(c >= 230 && c <= 280, 1'b1)
      // enable cannot be written back to zero
      wr(wdtrn_pkg::IDX_CTL, 8'h49);
      chk_rd(wdtrn_pkg::IDX_CTL, 32'h000000E9);
      // every period code on the system clock, last is the longest
      for (int p = 3; p >= 0; p--) begin
         wr(wdtrn_pkg::IDX_CTL, 8'hC0 | 8'(p));
         wait_nmi(300, c);
         wait_nmi(300, c);
         `CHK(c >= (1 << per_exp[p]) - 1, 1'b1)
         `CHK(c <= (1 << per_exp[p]) + 1, 1'b1)
      end
      // timely services keep the nmi away, five idle cycles between the bytes
      wait_nmi(100, c);
      n0 = n_nmi;
      for (int i = 0; i < 6; i++) begin
         repeat (30) @(posedge sys_clk);
         wr(wdtrn_pkg::IDX_SVC, 8'hA5);
         repeat (5) @(posedge sys_clk);
         wr(wdtrn_pkg::IDX_SVC, 8'h5A);
      end
      `CHK(n_nmi, n0)
      // a repeated first byte abandons the sequence, no reload follows
      wr(wdtrn_pkg::IDX_SVC, 8'hA5);
      wr(wdtrn_pkg::IDX_SVC, 8'hA5);
      wr(wdtrn_pkg::IDX_SVC, 8'h5A);
      wait_nmi(100, c);
      `CHK(c >= 40 && c <= 60, 1'b1)
      // service and abort events: masked, raised, cleared
      wb_xfer(1'b0, wdtrn_pkg::IDX_STS, 8'h00, x);
      `CHK(x[2:0], 3'h7)
      `CHK(irq, 1'b0)
      wr(wdtrn_pkg::IDX_MSK, 8'h06);
      @(posedge sys_clk);
      `CHK(irq, 1'b1)
      wr(wdtrn_pkg::IDX_STS, 8'h06);
      @(posedge sys_clk);
      `CHK(irq, 1'b0)
      chk_rd(wdtrn_pkg::IDX_MSK, 32'h00000006);
      // only the full-chip reset clears the cause flag
      por_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      por_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk_rd(wdtrn_pkg::IDX_CTL, 32'h00000000);
      give_verdict;
   end
endmodule // wdtrn_top_test
